// File: rtl/eetc_pkg.sv
// shared constants and types of the edge event timestamp capture pair
// assumes a single 25 MHz clock shared by both ends
package eetc_pkg;
	localparam int CH_N       = 16;
	localparam int GRP_N      = 8;
	localparam int TIME_W     = 32;
	localparam int ANGLE_W    = 11;
	localparam int DIV_W      = 5;
	localparam int VAL_W      = 16;
	localparam int SRC_W      = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int MEAS_N     = 64;
	// angle clocks per camshaft turn (720 deg crankshaft)
	localparam logic [ANGLE_W-1:0] ANGLE_TICKS  = 11'h5A0;
	localparam logic [ANGLE_W-1:0] ANGLE_ZERO   = 11'h000;
	localparam logic [ANGLE_W-1:0] ANGLE_STEP   = 11'h001;
	localparam logic [TIME_W-1:0]  TIME_ZERO    = 32'h0000_0000;
	localparam logic [TIME_W-1:0]  TIME_STEP    = 32'h0000_0001;
	localparam logic [CH_N-1:0]    LEVELS_RST   = 16'h0000;
	localparam logic [DIV_W-1:0]   DIV_CNT_RST  = 5'h00;
	localparam logic [DIV_W-1:0]   DIV_CNT_STEP = 5'h01;
	localparam logic [DIV_W-1:0]   DIV_MASK_1   = 5'h00;
	localparam logic [DIV_W-1:0]   DIV_MASK_2   = 5'h01;
	localparam logic [DIV_W-1:0]   DIV_MASK_4   = 5'h03;
	localparam logic [DIV_W-1:0]   DIV_MASK_8   = 5'h07;
	localparam logic [DIV_W-1:0]   DIV_MASK_16  = 5'h0F;
	localparam logic [DIV_W-1:0]   DIV_MASK_32  = 5'h1F;
	localparam logic [VAL_W-1:0]   VAL_ACTIVE   = 16'h0001;
	localparam logic [VAL_W-1:0]   VAL_INACTIVE = 16'h0000;

	typedef enum logic [1:0] {
		EETC_THR_FIXED = 2'h0,
		EETC_THR_BAT_A = 2'h1,
		EETC_THR_BAT_B = 2'h2,
		EETC_THR_EXT   = 2'h3
	} eetc_thr_type;

	typedef enum logic [2:0] {
		EETC_DIV_1  = 3'h0,
		EETC_DIV_2  = 3'h1,
		EETC_DIV_4  = 3'h2,
		EETC_DIV_8  = 3'h3,
		EETC_DIV_16 = 3'h4,
		EETC_DIV_32 = 3'h5
	} eetc_div_type;

	typedef enum logic [1:0] {
		EETC_TO_OFF   = 2'h0,
		EETC_TO_TIME  = 2'h1,
		EETC_TO_ANGLE = 2'h2,
		EETC_TO_BOTH  = 2'h3
	} eetc_trig_type;

	typedef enum logic {
		EETC_SUB_PREDEF = 1'h0,
		EETC_SUB_LEVEL  = 1'h1
	} eetc_sub_type;

	typedef struct packed {
		logic [CH_N-1:0]    levels;
		logic [TIME_W-1:0]  stamp;
		logic [ANGLE_W-1:0] angle;
	} eetc_record_type;
endpackage

// File: rtl/eetc_link_if.sv
// link between the capture hardware and the firmware end
// both ends run on the same clock; no clocking block
`timescale 1ns/1ns
`default_nettype none
interface eetc_link_if;
	import eetc_pkg::*;
	eetc_record_type    rec;
	logic               rec_valid;
	logic               rec_ready;
	logic               overflow;
	logic               overflow_clear;
	logic [CH_N-1:0]    cur_levels;
	logic [ANGLE_W-1:0] cur_angle;
	logic               angle_step;

	modport dev (
		output rec, rec_valid, overflow, cur_levels, cur_angle, angle_step,
		input  rec_ready, overflow_clear
	);
	modport fw (
		input  rec, rec_valid, overflow, cur_levels, cur_angle, angle_step,
		output rec_ready, overflow_clear
	);
endinterface
`default_nettype wire

// File: rtl/eetc_capture.sv
// capture end: thresholds, sampling, edge detection, stamping, event FIFO
// assumes comparator outputs and angle pulses synchronous to clk_i
// Contract
// - rising closes low pulse, falling closes high
// - falling opens low pulse, rising opens high
// - inactive: high in low-time, low in high-time
// - level is one above selected threshold
// - threshold source chosen per channel group
// - compare all sixteen levels with previous values
// - on toggle latch levels, time, angle
// - records enter FIFO without processor help
// - firmware reads records, derives edges and stamps; eetc_firmware derives edges only, stamp field unused
// - up to sixty-four measurement channels, any source
// - method, timeout, segmenting configured per channel
// - values update only on source edges
// - timeout check by time interval or angle
// - no edge since check: substitute value
// - level substitute gives zero or one
// - angle check once per 720 degree cycle
// - combined mode: either criterion times out
// - four timeout modes supported, off included
// - segmented evaluation confined to angle window
// - active: low in low-time, high in high-time
// - sample at clock, optionally divided by 2..32
// - angle counter steps per tick, fixed 1440
`timescale 1ns/1ns
`default_nettype none
module eetc_capture #(
	parameter int DEPTH = eetc_pkg::FIFO_DEPTH
) (
	input  wire logic                          clk_i,
	input  wire logic                          reset_i,
	input  wire logic [eetc_pkg::CH_N-1:0]     cmp_fixed_i,
	input  wire logic [eetc_pkg::CH_N-1:0]     cmp_bat_a_i,
	input  wire logic [eetc_pkg::CH_N-1:0]     cmp_bat_b_i,
	input  wire logic [eetc_pkg::CH_N-1:0]     cmp_ext_i,
	input  wire eetc_pkg::eetc_thr_type        thr_sel_lo_i,
	input  wire eetc_pkg::eetc_thr_type        thr_sel_hi_i,
	input  wire eetc_pkg::eetc_div_type        div_sel_i,
	input  wire logic                          angle_tick_i,
	input  wire logic                          cam_sync_i,
	input  wire logic [eetc_pkg::CH_N-1:0]     low_time_i,
	output logic      [eetc_pkg::CH_N-1:0]     active_o,
	output logic      [eetc_pkg::CH_N-1:0]     open_edge_o,
	output logic      [eetc_pkg::CH_N-1:0]     close_edge_o,
	output logic      [$clog2(DEPTH):0]        fifo_fill_o,
	eetc_link_if.dev                           link
);
	import eetc_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [CH_N-1:0]    level_raw;
	logic [CH_N-1:0]    level_q;
	logic [CH_N-1:0]    changed;
	logic [CH_N-1:0]    active_new;
	logic [DIV_W-1:0]   div_cnt;
	logic [DIV_W-1:0]   div_mask;
	logic               sample_en;
	logic               change_any;
	logic [TIME_W-1:0]  time_cnt;
	logic [ANGLE_W-1:0] angle_cnt;
	eetc_record_type    mem [DEPTH];
	logic [AW:0]        wr_ptr;
	logic [AW:0]        rd_ptr;
	logic               full;
	logic               empty;
	logic               push;
	logic               pop;
	logic               overflow;
	logic               angle_step;

	function automatic logic pick(eetc_thr_type sel, logic f, logic a,
		logic b, logic e);
		case (sel)
			EETC_THR_FIXED: pick = f;
			EETC_THR_BAT_A: pick = a;
			EETC_THR_BAT_B: pick = b;
			EETC_THR_EXT:   pick = e;
			default:        pick = f;
		endcase
	endfunction

	// each comparator already reports 1 above its threshold
	for (genvar i = 0; i < CH_N; i++) begin : g_thr
		if (i < GRP_N) begin : g_lo
			assign level_raw[i] = pick(thr_sel_lo_i, cmp_fixed_i[i],
				cmp_bat_a_i[i], cmp_bat_b_i[i], cmp_ext_i[i]);
		end else begin : g_hi
			assign level_raw[i] = pick(thr_sel_hi_i, cmp_fixed_i[i],
				cmp_bat_a_i[i], cmp_bat_b_i[i], cmp_ext_i[i]);
		end
	end

	// sampling divider: a pulse whenever the masked low bits are all ones
	always_comb begin
		case (div_sel_i)
			EETC_DIV_1:  div_mask = DIV_MASK_1;
			EETC_DIV_2:  div_mask = DIV_MASK_2;
			EETC_DIV_4:  div_mask = DIV_MASK_4;
			EETC_DIV_8:  div_mask = DIV_MASK_8;
			EETC_DIV_16: div_mask = DIV_MASK_16;
			EETC_DIV_32: div_mask = DIV_MASK_32;
			default:     div_mask = DIV_MASK_1;
		endcase
	end
	assign sample_en = ((div_cnt & div_mask) == div_mask);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_cnt <= DIV_CNT_RST;
		end else begin
			div_cnt <= div_cnt + DIV_CNT_STEP;
		end
	end

	// free-running time base in clock cycles
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			time_cnt <= TIME_ZERO;
		end else begin
			time_cnt <= time_cnt + TIME_STEP;
		end
	end

	// sync pulse wins over a tick in the same cycle and restarts at zero
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			angle_cnt  <= ANGLE_ZERO;
			angle_step <= 1'b0;
		end else begin
			angle_step <= angle_tick_i | cam_sync_i;
			if (cam_sync_i) begin
				angle_cnt <= ANGLE_ZERO;
			end else if (angle_tick_i) begin
				if (angle_cnt == ANGLE_TICKS - ANGLE_STEP) begin
					angle_cnt <= ANGLE_ZERO;
				end else begin
					angle_cnt <= angle_cnt + ANGLE_STEP;
				end
			end
		end
	end

	assign changed    = level_raw ^ level_q;
	assign change_any = sample_en & (|changed);
	// low-time channels are active when low
	assign active_new = level_raw ^ low_time_i;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			level_q <= LEVELS_RST;
		end else if (sample_en) begin
			level_q <= level_raw;
		end
	end

	// per-channel edge classes, one-cycle pulses aligned with the sample
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			active_o     <= LEVELS_RST;
			open_edge_o  <= LEVELS_RST;
			close_edge_o <= LEVELS_RST;
		end else begin
			if (sample_en) begin
				active_o <= active_new;
			end
			open_edge_o  <= {CH_N{sample_en}} & changed & active_new;
			close_edge_o <= {CH_N{sample_en}} & changed & ~active_new;
		end
	end

	assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = (wr_ptr == rd_ptr);
	assign push  = change_any & ~full;
	assign pop   = ~empty & link.rec_ready;

	// records are stored by hardware alone; a full FIFO keeps older data
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= '{levels: level_raw, stamp: time_cnt,
				angle: angle_cnt};
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// a drop in the same cycle as a clear keeps the flag set
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			overflow <= 1'b0;
		end else if (change_any & full) begin
			overflow <= 1'b1;
		end else if (link.overflow_clear) begin
			overflow <= 1'b0;
		end
	end

	assign fifo_fill_o     = wr_ptr - rd_ptr;
	assign link.rec        = mem[rd_ptr[AW-1:0]];
	assign link.rec_valid  = ~empty;
	assign link.overflow   = overflow;
	assign link.cur_levels = level_q;
	assign link.cur_angle  = angle_cnt;
	assign link.angle_step = angle_step;
endmodule
`default_nettype wire

// File: rtl/eetc_firmware.sv
// firmware end: drains event records into per-channel level measurements
// with timeout monitoring; configured over a simple write port
`timescale 1ns/1ns
`default_nettype none
module eetc_firmware #(
	parameter int MEAS = eetc_pkg::MEAS_N
) (
	input  wire logic                          clk_i,
	input  wire logic                          reset_i,
	input  wire logic                          cfg_we_i,
	input  wire logic [$clog2(MEAS)-1:0]       cfg_idx_i,
	input  wire logic [eetc_pkg::SRC_W-1:0]    cfg_src_i,
	input  wire eetc_pkg::eetc_trig_type       cfg_trig_i,
	input  wire eetc_pkg::eetc_sub_type        cfg_sub_i,
	input  wire logic                          cfg_low_time_i,
	input  wire logic                          cfg_segmented_i,
	input  wire logic [eetc_pkg::ANGLE_W-1:0]  cfg_check_angle_i,
	input  wire logic [eetc_pkg::ANGLE_W-1:0]  angle_window_low_limit_i,
	input  wire logic [eetc_pkg::ANGLE_W-1:0]  angle_window_high_limit_i,
	input  wire logic [eetc_pkg::VAL_W-1:0]    cfg_default_i,
	input  wire logic [eetc_pkg::TIME_W-1:0]   interval_i,
	input  wire logic                          drain_en_i,
	input  wire logic                          overflow_clear_i,
	input  wire logic [$clog2(MEAS)-1:0]       rd_idx_i,
	output logic      [eetc_pkg::VAL_W-1:0]    rd_value_o,
	output logic                               rd_timeout_o,
	output logic                               overflow_o,
	eetc_link_if.fw                            link
);
	import eetc_pkg::*;

	logic [CH_N-1:0]    last_lv;
	logic [TIME_W-1:0]  ivl_cnt;
	logic               time_check;
	logic               pop;
	logic [VAL_W-1:0]   val     [MEAS];
	logic               tmo     [MEAS];

	assign pop                 = link.rec_valid & drain_en_i;
	assign link.rec_ready      = drain_en_i;
	assign link.overflow_clear = overflow_clear_i;
	assign overflow_o          = link.overflow;

	// previous record levels, to tell which inputs changed
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			last_lv <= LEVELS_RST;
		end else if (pop) begin
			last_lv <= link.rec.levels;
		end
	end

	// shared interval timer; an interval of zero disables time checks
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ivl_cnt <= TIME_ZERO;
		end else if (time_check || interval_i == TIME_ZERO) begin
			ivl_cnt <= TIME_ZERO;
		end else begin
			ivl_cnt <= ivl_cnt + TIME_STEP;
		end
	end
	assign time_check = (interval_i != TIME_ZERO) &&
		(ivl_cnt == interval_i - TIME_STEP);

	for (genvar m = 0; m < MEAS; m++) begin : g_meas
		logic [SRC_W-1:0]   src;
		eetc_trig_type      trig;
		eetc_sub_type       sub;
		logic               low_time;
		logic               seg;
		logic [ANGLE_W-1:0] chk_ang;
		logic [ANGLE_W-1:0] win_lo;
		logic [ANGLE_W-1:0] win_hi;
		logic [VAL_W-1:0]   dflt;
		logic               seen;
		logic               in_win;
		logic               evaluated;
		logic               act_rec;
		logic               act_now;
		logic               check;

		assign in_win = ~seg || (link.rec.angle >= win_lo &&
			link.rec.angle <= win_hi);
		assign evaluated = pop & in_win &
			(link.rec.levels[src] ^ last_lv[src]);
		assign act_rec = link.rec.levels[src] ^ low_time;
		assign act_now = link.cur_levels[src] ^ low_time;
		// angle check fires once per cycle when the counter lands there
		assign check = ((trig == EETC_TO_TIME || trig == EETC_TO_BOTH) &&
			time_check) || ((trig == EETC_TO_ANGLE || trig == EETC_TO_BOTH) &&
			link.angle_step && link.cur_angle == chk_ang);

		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				src      <= '0;
				trig     <= EETC_TO_OFF;
				sub      <= EETC_SUB_PREDEF;
				low_time <= 1'b0;
				seg      <= 1'b0;
				chk_ang  <= ANGLE_ZERO;
				win_lo   <= ANGLE_ZERO;
				win_hi   <= ANGLE_ZERO;
				dflt     <= VAL_INACTIVE;
			end else if (cfg_we_i && cfg_idx_i == m) begin
				src      <= cfg_src_i;
				trig     <= cfg_trig_i;
				sub      <= cfg_sub_i;
				low_time <= cfg_low_time_i;
				seg      <= cfg_segmented_i;
				chk_ang  <= cfg_check_angle_i;
				win_lo   <= angle_window_low_limit_i;
				win_hi   <= angle_window_high_limit_i;
				dflt     <= cfg_default_i;
			end
		end

		// an edge in the check cycle counts as seen after that check
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				val[m] <= VAL_INACTIVE;
				tmo[m] <= 1'b0;
				seen   <= 1'b0;
			end else if (evaluated) begin
				val[m] <= act_rec ? VAL_ACTIVE : VAL_INACTIVE;
				tmo[m] <= 1'b0;
				seen   <= 1'b1;
			end else if (check) begin
				seen <= 1'b0;
				if (!seen) begin
					tmo[m] <= 1'b1;
					if (sub == EETC_SUB_LEVEL) begin
						val[m] <= act_now ? VAL_ACTIVE : VAL_INACTIVE;
					end else begin
						val[m] <= dflt;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_value_o   <= VAL_INACTIVE;
			rd_timeout_o <= 1'b0;
		end else begin
			rd_value_o   <= val[rd_idx_i];
			rd_timeout_o <= tmo[rd_idx_i];
		end
	end
endmodule
`default_nettype wire

// File: tb/eetc_link_monitor.sv
// link checker: watches the capture to firmware record stream
// assumes one clock; the bench instantiates it beside the link
`timescale 1ns/1ns
`default_nettype none
module eetc_link_monitor (
	input wire logic                         clk_i,
	input wire logic                         reset_i,
	input wire eetc_pkg::eetc_record_type    rec,
	input wire logic                         rec_valid,
	input wire logic                         rec_ready,
	input wire logic                         overflow,
	input wire logic                         overflow_clear,
	input wire logic [eetc_pkg::CH_N-1:0]    cur_levels,
	input wire logic [eetc_pkg::ANGLE_W-1:0] cur_angle,
	input wire logic                         angle_step
);
	import eetc_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	chk_head_holds: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec))
		else $error("record head moved before pop");
	chk_ovf_sticky: assert property (overflow && !overflow_clear |=> overflow)
		else $error("overflow dropped without clear");
	chk_ovf_cause: assert property ($rose(overflow) |-> $past(rec_valid))
		else $error("overflow set with empty fifo");
	// an empty fifo cannot drop, so the clear must win
	chk_ovf_clear: assert property (overflow && overflow_clear && !rec_valid |=> !overflow)
		else $error("overflow clear ignored");
	chk_angle_step: assert property (angle_step |-> cur_angle == ANGLE_ZERO || cur_angle == $past(cur_angle) + ANGLE_STEP)
		else $error("angle step not by one");
	chk_angle_quiet: assert property (!angle_step |-> $stable(cur_angle))
		else $error("angle moved without step");
	chk_change_logged: assert property ($changed(cur_levels) |-> rec_valid)
		else $error("level change left no record");
	chk_head_levels: assert property ($rose(rec_valid) |-> rec.levels == cur_levels)
		else $error("record levels differ from sample");
endmodule
`default_nettype wire

// File: tb/edge_event_timestamp_capture_bench.sv
// bench: capture and firmware ends joined by the link
// assumes rtl files and the link monitor are compiled first
`timescale 1ns/1ns
`default_nettype none
module edge_event_timestamp_capture_bench;
	import eetc_pkg::*;
	logic            clk_i = 1'b0;
	logic            reset_i = 1'b1;
	logic [CH_N-1:0] cmp [4] = '{4{16'h0000}};
	eetc_thr_type    thr_lo = EETC_THR_FIXED;
	eetc_thr_type    thr_hi = EETC_THR_FIXED;
	eetc_div_type    div_sel = EETC_DIV_1;
	eetc_trig_type   trig = EETC_TO_OFF;
	eetc_sub_type    sub = EETC_SUB_PREDEF;
	logic            tick = 1'b0;
	logic            sync_p = 1'b0;
	logic            we = 1'b0;
	logic            seg = 1'b0;
	logic            cfg_lt = 1'b0;
	logic            drain = 1'b1;
	logic            oclr = 1'b0;
	logic [CH_N-1:0] lt = 16'h00F0;
	logic [5:0]      idx = 6'h00;
	logic [5:0]      rd_idx = 6'h00;
	logic [31:0]     intv = 32'h0000_0400;
	logic [CH_N-1:0] active, open_e, close_e, lv, n, r, f, seen;
	logic [4:0]      fill;
	logic [15:0]     rd_val;
	logic            rd_to, ovf;
	logic [31:0]     s;
	int              i, j, k, last, gap, n_fail, cmp_count;
	eetc_link_if link ();
	eetc_capture u_eetc_capture (.clk_i(clk_i), .reset_i(reset_i),
		.cmp_fixed_i(cmp[0]), .cmp_bat_a_i(cmp[1]), .cmp_bat_b_i(cmp[2]),
		.cmp_ext_i(cmp[3]), .thr_sel_lo_i(thr_lo), .thr_sel_hi_i(thr_hi),
		.div_sel_i(div_sel), .angle_tick_i(tick), .cam_sync_i(sync_p),
		.low_time_i(lt), .active_o(active), .open_edge_o(open_e),
		.close_edge_o(close_e), .fifo_fill_o(fill), .link(link));
	eetc_firmware u_eetc_firmware (.clk_i(clk_i), .reset_i(reset_i),
		.cfg_we_i(we), .cfg_idx_i(idx), .cfg_src_i(4'h3), .cfg_trig_i(trig),
		.cfg_sub_i(sub), .cfg_low_time_i(cfg_lt), .cfg_segmented_i(seg),
		.cfg_check_angle_i(11'h0A0), .angle_window_low_limit_i(11'h064),
		.angle_window_high_limit_i(11'h0C8), .cfg_default_i(16'h0033),
		.interval_i(intv), .drain_en_i(drain), .overflow_clear_i(oclr),
		.rd_idx_i(rd_idx), .rd_value_o(rd_val), .rd_timeout_o(rd_to),
		.overflow_o(ovf), .link(link));
	eetc_link_monitor u_eetc_link_monitor (.clk_i(clk_i), .reset_i(reset_i),
		.rec(link.rec), .rec_valid(link.rec_valid),
		.rec_ready(link.rec_ready), .overflow(link.overflow),
		.overflow_clear(link.overflow_clear), .cur_levels(link.cur_levels),
		.cur_angle(link.cur_angle), .angle_step(link.angle_step));
	always #20 clk_i = ~clk_i;
	task automatic give_verdict;
		if (n_fail == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input int c, input logic [15:0] v, input logic t);
		@(posedge clk_i);
		rd_idx <= 6'(c);
		@(posedge clk_i);
		#1;
		chk("value", v, rd_val);
		chk("timeout", t, rd_to);
	endtask
	// firmware sees a level change two clocks later, inside the four-clock wait
	task automatic lvl(input logic [15:0] v);
		@(posedge clk_i);
		cmp[0] <= v;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic ticks(input int cnt);
		repeat (cnt) begin
			@(posedge clk_i);
			tick <= 1'b1;
		end
		@(posedge clk_i);
		tick <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		n_fail++;
		give_verdict;
	end
	initial begin
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("fill", 5'h00, fill);
		chk("overflow", 1'b0, ovf);
		@(posedge clk_i);
		we <= 1'b1;
		for (i = 0; i < 7; i++) begin
			idx <= 6'(i);
			trig <= (i == 6) ? EETC_TO_OFF : eetc_trig_type'(i % 3 + 1);
			sub <= eetc_sub_type'(i > 2);
			seg <= (i == 6);
			// the windowed channel measures low time, so a high input is idle
			cfg_lt <= (i == 6);
			@(posedge clk_i);
		end
		we <= 1'b0;
		lvl(16'h0008);
		for (i = 0; i < 7; i++) rd(i, 16'(i < 6), 1'b0);
		ticks(150);
		chk("angle", 11'h096, link.cur_angle);
		lvl(16'h0000);
		lvl(16'h0008);
		rd(6, 16'h0000, 1'b0);
		ticks(20);
		@(posedge clk_i);
		sync_p <= 1'b1;
		@(posedge clk_i);
		sync_p <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("angle", 11'h000, link.cur_angle);
		ticks(170);
		// outlast two time checks so every timed channel has expired
		repeat (1900) @(posedge clk_i);
		for (i = 0; i < 7; i++) rd(i, (i < 3) ? 16'h0033 : 16'(i < 6), i < 6);
		ticks(1270);
		chk("angle", 11'h000, link.cur_angle);
		lv = 16'h0008;
		for (k = 0; k < 4; k++) begin
			@(posedge clk_i);
			thr_lo <= eetc_thr_type'(k);
			thr_hi <= eetc_thr_type'(3 - k);
			for (j = 0; j < 4; j++) cmp[j] <= 16'h3C5A * 16'(j + 1) + 16'h1357 * 16'(k);
			n = 16'h3C5A * 16'(k + 1) + 16'h1357 * 16'(k);
			s = 32'(16'h3C5A * 16'(4 - k) + 16'h1357 * 16'(k));
			n = {s[15:8], n[7:0]};
			@(posedge clk_i);
			#1;
			chk("levels", n, link.cur_levels);
			chk("active", n ^ lt, active);
			r = n & ~lv;
			f = ~n & lv;
			chk("open", (r & ~lt) | (f & lt), open_e);
			chk("close", (f & ~lt) | (r & lt), close_e);
			lv = n;
		end
		@(posedge clk_i);
		drain <= 1'b0;
		thr_lo <= EETC_THR_FIXED;
		thr_hi <= EETC_THR_FIXED;
		cmp[0] <= 16'h1000;
		for (j = 1; j < 17; j++) begin
			@(posedge clk_i);
			cmp[0] <= 16'h1000 + 16'(j);
		end
		@(posedge clk_i);
		#1;
		chk("fill", 5'h10, fill);
		chk("overflow", 1'b1, ovf);
		chk("head", 16'h1000, link.rec.levels);
		chk("head angle", 11'h000, link.rec.angle);
		s = link.rec.stamp;
		@(posedge clk_i);
		drain <= 1'b1;
		for (j = 1; j < 16; j++) begin
			@(posedge clk_i);
			#1;
			chk("stamp", s + 32'(j), link.rec.stamp);
		end
		@(posedge clk_i);
		#1;
		chk("fill", 5'h00, fill);
		@(posedge clk_i);
		oclr <= 1'b1;
		@(posedge clk_i);
		oclr <= 1'b0;
		#1;
		chk("overflow", 1'b0, ovf);
		for (k = 1; k < 6; k++) begin
			@(posedge clk_i);
			div_sel <= eetc_div_type'(k);
			last = -1;
			gap = 0;
			seen = link.cur_levels;
			for (j = 0; j < 100; j++) begin
				@(posedge clk_i);
				cmp[0] <= cmp[0] + 16'h0001;
				#1;
				if (link.cur_levels !== seen) begin
					gap = j - last;
					last = j;
					seen = link.cur_levels;
				end
			end
			chk("sample gap", 1 << k, gap);
		end
		give_verdict;
	end
endmodule
`default_nettype wire
